// ---- common/nopor_pkg.sv ----
package nopor_pkg;
    localparam logic [7:0] OPC_NOP = 8'hff;
    localparam logic [7:0] OPC_OR_RR = 8'h42;
    localparam logic [7:0] OPC_OR_RIR = 8'h43;
    localparam logic [7:0] OPC_OR_GR = 8'h44;
    localparam logic [7:0] OPC_OR_GIR = 8'h45;
    localparam logic [7:0] OPC_OR_IM = 8'h46;
    localparam logic [3:0] CYC_NOP = 4'h4;
    localparam logic [3:0] CYC_OR_RR = 4'h4;
    localparam logic [3:0] CYC_OR_LONG = 4'h6;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] WREG_BASE_RESET = 8'hc0;
    typedef enum logic [1:0] {NP_IDLE, NP_FETCH, NP_EXEC, NP_WAIT} nopor_state_type;
endpackage

// ---- tb/nop_and_logical_or_execution_tb.sv ----
`timescale 1ns/1ps
module nop_and_logical_or_execution_tb;
import nopor_pkg::*;
logic clk = 1'b0;
logic rst = 1'b1;
logic start = 1'b0;
logic busy, done, illegal;
logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00, wregBase = 8'h00;
logic [7:0] flags, dbgData;
logic [1:0] instrLen;
logic [7:0] mem [256] = '{default: REG_RESET};
logic [7:0] expFlags = FLAGS_RESET;
logic [7:0] expData = 8'h00;
logic [7:0] ops [6] = '{OPC_NOP, OPC_OR_RR, OPC_OR_RIR, OPC_OR_GR, OPC_OR_GIR, OPC_OR_IM};
bit [31:0] seed = 74953;
int num_errors = 0;
int total_checks = 0;

always #2 clk = ~clk;

nopor_exec nopor_exec_inst (.clk(clk), .rst(rst), .start(start), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .wregBase(wregBase), .busy(busy), .done(done),
    .illegal(illegal), .instrLen(instrLen), .flags(flags), .dbgData(dbgData));

////////////////////////////////////////////////////////////////////////////////
function automatic bit [31:0] lfsr(input bit [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction

task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
        num_errors++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
endtask

task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask

// The register file clears on reset and has no load port, so the model starts from zeros.
task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    int n;
    int cnt;
    logic [7:0] d;
    logic [7:0] sp;
    logic [7:0] s;
    logic [1:0] len;
    logic wide;
    wide = (op == OPC_OR_RR || op == OPC_OR_RIR);
    n = (op == OPC_NOP || op == OPC_OR_RR) ? 4 : 6;
    len = (op == OPC_NOP) ? LEN_ONE : wide ? LEN_TWO : LEN_THREE;
    d = wide ? (wregBase | {4'h0, a[7:4]}) : (op == OPC_OR_IM) ? a : b;
    sp = wide ? (wregBase | {4'h0, a[3:0]}) : a;
    s = (op == OPC_OR_IM) ? b : (op == OPC_OR_RIR || op == OPC_OR_GIR) ? mem[mem[sp]] : mem[sp];
    opcode = op;
    operand1 = a;
    operand2 = b;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    cnt = 0;
    while (done !== 1'b1 && cnt < 20) begin
        chk({7'h0, busy}, 8'h01);
        @(posedge clk);
        #1 cnt++;
        // A second start while busy must not restart the count.
        if (cnt == 1) begin
            start = 1'b1;
        end else if (cnt == 2) begin
            start = 1'b0;
        end
    end
    chk(8'(cnt), 8'(n));
    chk({6'h0, instrLen}, {6'h0, len});
    if (op != OPC_NOP) begin
        expData = mem[d] | s;
        mem[d] = expData;
        expFlags = {expFlags[7], expData == 8'h00, expData[7], 1'b0, expFlags[3:0]};
    end
    chk(dbgData, expData);
    chk(flags, expFlags);
endtask

task automatic bad();
    opcode = 8'h00;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    chk({6'h0, illegal, busy}, 8'h02);
    @(posedge clk);
    #1 chk({6'h0, illegal, busy}, 8'h00);
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 256; i++) begin
        seed = lfsr(seed);
        // Every fourth register stays zero, so zero results and a clear sign come up.
        run(OPC_OR_IM, 8'(i), (i % 4 == 0) ? 8'h00 : (seed[7:0] & seed[15:8]));
    end
    $display("test fill done");
    run(OPC_NOP, 8'h00, 8'h00);
    run(OPC_NOP, 8'h00, 8'h00);
    bad();
    $display("test nop and unknown opcode done");
    for (int i = 0; i < 200; i++) begin
        seed = lfsr(seed);
        wregBase = seed[15:8];
        run(ops[seed[18:16] % 6], seed[7:0], seed[31:24]);
    end
    $display("test random mix done");
    close_out();
end

// About 3000 cycles are expected; this leaves a wide margin.
initial begin
    #60000;
    num_errors++;
    close_out();
end

endmodule

// ---- verilog/nopor_exec.sv ----
`timescale 1ns/1ps
// How it works
// - Opcode ff is a no-operation that changes no state and lasts four cycles.
// - OR combines source and destination bitwise and writes the result to the destination.
// - OR writes only the destination; the source changes only when it is that same location, directly or indirectly.
// - Each result bit is one when either operand bit is one, else zero.
// - OR sets zero when the result is zero and keeps carry, decimal-adjust and half-carry.
// - OR copies result bit 7 into sign and always clears overflow.
module nopor_exec
    import nopor_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [7:0] wregBase,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic [1:0] instrLen,
    output logic [7:0] flags,
    output logic [7:0] dbgData
);
    //////////////////////////////////////////////////////////////////////////////
    // Register file lives here; its write port is the OR destination only.
    logic [7:0] regFile [DEPTH];
    typedef struct packed {
        nopor_state_type st;
        logic [3:0] cnt;
        logic [7:0] op;
        logic [7:0] dstAddr;
        logic [7:0] srcAddr;
        logic [7:0] imm;
        logic isNop;
        logic useImm;
        logic indir;
        logic busy;
        logic done;
        logic illegal;
        logic [1:0] len;
        logic [7:0] flags;
        logic [7:0] dbg;
        logic wrEn;
        logic [7:0] wrAddr;
        logic [7:0] wrData;
    } nopor_st_type;
    nopor_st_type s_reg, s_next;
    logic [7:0] srcVal;
    logic [7:0] dstVal;
    logic [7:0] result;

    // Indirect source reads the pointer register, then the pointed-to byte.
    assign srcVal = s_reg.useImm ? s_reg.imm :
        (s_reg.indir ? regFile[regFile[s_reg.srcAddr]] : regFile[s_reg.srcAddr]);
    assign dstVal = regFile[s_reg.dstAddr];
    assign result = dstVal | srcVal;

    //////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.wrEn = 1'b0;
        case (s_reg.st)
            NP_IDLE: begin
                s_next.illegal = 1'b0;
                if (start) begin
                    s_next.op = opcode;
                    s_next.busy = 1'b1;
                    s_next.isNop = 1'b0;
                    s_next.useImm = 1'b0;
                    s_next.indir = 1'b0;
                    s_next.imm = operand2;
                    s_next.st = NP_EXEC;
                    case (opcode)
                        OPC_NOP: begin
                            s_next.isNop = 1'b1;
                            s_next.cnt = CYC_NOP;
                            s_next.len = LEN_ONE;
                        end
                        OPC_OR_RR, OPC_OR_RIR: begin
                            s_next.dstAddr = wregBase | {4'h0, operand1[7:4]};
                            s_next.srcAddr = wregBase | {4'h0, operand1[3:0]};
                            s_next.indir = (opcode == OPC_OR_RIR);
                            s_next.cnt = (opcode == OPC_OR_RR) ? CYC_OR_RR : CYC_OR_LONG;
                            s_next.len = LEN_TWO;
                        end
                        OPC_OR_GR, OPC_OR_GIR, OPC_OR_IM: begin
                            s_next.dstAddr = (opcode == OPC_OR_IM) ? operand1 : operand2;
                            s_next.srcAddr = operand1;
                            s_next.indir = (opcode == OPC_OR_GIR);
                            s_next.useImm = (opcode == OPC_OR_IM);
                            s_next.cnt = CYC_OR_LONG;
                            s_next.len = LEN_THREE;
                        end
                        default: begin
                            s_next.illegal = 1'b1;
                            s_next.busy = 1'b0;
                            s_next.st = NP_IDLE;
                        end
                    endcase
                end
            end
            NP_EXEC: begin
                // Operands are read and the result computed in one cycle; the write lands one cycle later; the rest is waiting.
                if (!s_reg.isNop) begin
                    s_next.wrEn = 1'b1;
                    s_next.wrAddr = s_reg.dstAddr;
                    s_next.wrData = result;
                    s_next.dbg = result;
                    s_next.flags[FLAG_Z] = (result == 8'h00);
                    s_next.flags[FLAG_S] = result[7];
                    s_next.flags[FLAG_V] = 1'b0;
                end
                s_next.cnt = s_reg.cnt - 4'h1;
                s_next.st = NP_WAIT;
            end
            NP_WAIT: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.st = NP_IDLE;
                end
            end
            default: s_next.st = NP_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.flags <= FLAGS_RESET;
            s_reg.st <= NP_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Only the destination is ever written, so the source changes only when it, or for indirect forms its pointer register, is the destination.
    // The file clears on reset because OR can only set bits: from unknown contents a zero
    // result could never be reached. The price is a reset on every entry.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                regFile[i] <= REG_RESET;
            end
        end else if (s_reg.wrEn) begin
            regFile[s_reg.wrAddr] <= s_reg.wrData;
        end
    end

    assign busy = s_reg.busy;
    assign done = s_reg.done;
    assign illegal = s_reg.illegal;
    assign instrLen = s_reg.len;
    assign flags = s_reg.flags;
    assign dbgData = s_reg.dbg;

    //////////////////////////////////////////////////////////////////////////////
    logic [3:0] runCnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runCnt <= 4'h0;
        end else if (start && !busy) begin
            runCnt <= 4'h1;
        end else if (busy) begin
            runCnt <= runCnt + 4'h1;
        end
    end

    property p_nop_len;
        @(posedge clk) disable iff (rst)
        (start && !busy && opcode == OPC_NOP) |=> busy [*4] ##1 done;
    endproperty
    a_nop_len: assert property (p_nop_len) else $error("nop length wrong");

    property p_nop_flags;
        @(posedge clk) disable iff (rst)
        (s_reg.isNop && busy) |-> (flags == $past(flags) && !s_reg.wrEn);
    endproperty
    a_nop_flags: assert property (p_nop_flags) else $error("nop changed state");

    property p_or_data;
        @(posedge clk) disable iff (rst)
        (s_reg.st == NP_EXEC && !s_reg.isNop) |=> s_reg.wrEn
            && s_reg.wrAddr == $past(s_reg.dstAddr);
    endproperty
    a_or_data: assert property (p_or_data) else $error("wrong destination");

    property p_or_bits;
        @(posedge clk) disable iff (rst)
        (s_reg.st == NP_EXEC && !s_reg.isNop) |=> s_reg.wrData == ($past(dstVal) | $past(srcVal));
    endproperty
    a_or_bits: assert property (p_or_bits) else $error("or result wrong");

    property p_keep_flags;
        @(posedge clk) disable iff (rst)
        s_reg.st == NP_EXEC |=> flags[FLAG_C] == $past(flags[FLAG_C])
            && flags[FLAG_D] == $past(flags[FLAG_D]) && flags[FLAG_H] == $past(flags[FLAG_H]);
    endproperty
    a_keep_flags: assert property (p_keep_flags) else $error("c d h changed");

    property p_zs;
        @(posedge clk) disable iff (rst)
        s_reg.wrEn |-> flags[FLAG_Z] == (s_reg.wrData == 8'h00)
            && flags[FLAG_S] == s_reg.wrData[7] && !flags[FLAG_V];
    endproperty
    a_zs: assert property (p_zs) else $error("z s v wrong");

    property p_rr_len;
        @(posedge clk) disable iff (rst)
        (start && !busy && opcode == OPC_OR_RR) |=> busy [*4] ##1 (done && instrLen == LEN_TWO);
    endproperty
    a_rr_len: assert property (p_rr_len) else $error("42 timing wrong");

    property p_long_len;
        @(posedge clk) disable iff (rst)
        (start && !busy && (opcode == OPC_OR_RIR || opcode == OPC_OR_GR
            || opcode == OPC_OR_GIR || opcode == OPC_OR_IM)) |=> busy [*6] ##1 done;
    endproperty
    a_long_len: assert property (p_long_len) else $error("six cycle form wrong");

    property p_one_write;
        @(posedge clk) disable iff (rst)
        s_reg.wrEn |=> !s_reg.wrEn;
    endproperty
    a_one_write: assert property (p_one_write) else $error("double write");

    property p_src_kept;
        @(posedge clk) disable iff (rst)
        (s_reg.wrEn && !s_reg.useImm && s_reg.srcAddr != s_reg.wrAddr
            && (!s_reg.indir || regFile[s_reg.srcAddr] != s_reg.wrAddr)) |=> $stable(srcVal);
    endproperty
    a_src_kept: assert property (p_src_kept) else $error("source changed");

    property p_done_cnt;
        @(posedge clk) disable iff (rst)
        done |-> runCnt == ((s_reg.op == OPC_NOP) ? CYC_NOP
            : (s_reg.op == OPC_OR_RR) ? CYC_OR_RR : CYC_OR_LONG) + 4'h1;
    endproperty
    a_done_cnt: assert property (p_done_cnt) else $error("cycle count wrong");
endmodule
